// ==== logic/sts_tx_serializer.sv ====
// transmit parallel-to-serial section with byte clock generation
// clk stands for the synthesized serial bit clock: one bit leaves per rising edge.
module sts_tx_serializer #(
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration
    input wire logic rate_high,
    input wire logic ref_high,
    input wire logic byte_clock_direction_sel,
    // reference clocks
    input wire logic diff_reference_clock,
    input wire logic single_ended_reference_clock,
    // parallel transmit bus
    input wire logic [DATA_W-1:0] tx_parallel_byte,
    // byte clock pin, two-way
    input wire logic tx_byte_clock_pin_in,
    output logic tx_byte_clock_pin_out,
    output logic tx_byte_clock_pin_oe,
    // serial line
    output logic serial_tx_output,
    // status
    output logic clock_multiplier_locked,
    output logic byte_underrun,
    output logic byte_clock_period_err
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic byte_clk;
        logic [DATA_W-1:0] hold;
        logic hold_valid;
        logic [DATA_W-1:0] shift;
        logic pin_in_prev;
        logic in_seen;
        logic [5:0] in_period;
        logic period_err;
        logic underrun;
    } sts_tx_reg_t;

    sts_tx_reg_t st_reg;
    sts_tx_reg_t st_next;
    sts_pkg::sts_cfg_t cfg;
    logic out_mode;
    logic capture;
    logic in_rise;
    logic byte_end;

    assign cfg = '{rate_high: rate_high, ref_high: ref_high,
                   byte_clock_direction_sel: byte_clock_direction_sel};

    // ****************************************
    // clock multiplier
    // ****************************************
    sts_clock_multiplier u_clock_multiplier (
        .clk(clk),
        .sys_rst(sys_rst),
        .diff_reference_clock(diff_reference_clock),
        .single_ended_reference_clock(single_ended_reference_clock),
        .cfg(cfg),
        .clock_multiplier_locked(clock_multiplier_locked)
    );

    // ****************************************
    // capture and shift
    // ****************************************
    assign out_mode = cfg.byte_clock_direction_sel;
    // pin input is synchronous, so a plain edge detect is safe
    assign in_rise = tx_byte_clock_pin_in & ~st_reg.pin_in_prev;
    // output mode: sample in the first cycle the driven byte clock is high
    assign capture = out_mode ? (st_reg.byte_clk && st_reg.bit_cnt == sts_pkg::BIT_CNT_RESET)
                              : in_rise;
    assign byte_end = (st_reg.bit_cnt == sts_pkg::BIT_CNT_LAST);

    always_comb begin
        st_next = st_reg;
        // divide-by-eight of the serial clock
        st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
        st_next.byte_clk = (st_next.bit_cnt <= sts_pkg::BYTE_CLK_HIGH_LAST);
        st_next.pin_in_prev = tx_byte_clock_pin_in;
        st_next.underrun = 1'b0;
        // one bit per serial clock, msb first
        st_next.shift = {st_reg.shift[DATA_W-2:0], 1'b0};
        if (byte_end) begin
            // one byte per byte clock; a missing byte sends idle rather than stale data
            if (st_reg.hold_valid || capture) begin
                st_next.shift = capture ? tx_parallel_byte : st_reg.hold;
            end else begin
                st_next.shift = sts_pkg::IDLE_BYTE;
                st_next.underrun = 1'b1;
            end
            st_next.hold_valid = 1'b0;
        end
        if (capture && !byte_end) begin
            st_next.hold = tx_parallel_byte;
            st_next.hold_valid = 1'b1;
        end
        // framer-driven byte clock must span exactly eight serial bits
        st_next.period_err = 1'b0;
        if (st_reg.in_period != sts_pkg::IN_PERIOD_MAX) begin
            st_next.in_period = st_reg.in_period + 6'h01;
        end
        if (!out_mode && in_rise) begin
            st_next.in_seen = 1'b1;
            st_next.in_period = 6'h01;
            st_next.period_err = st_reg.in_seen && (st_reg.in_period != 6'(sts_pkg::BYTE_BITS));
        end
        if (out_mode) begin
            st_next.in_seen = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '{bit_cnt: sts_pkg::BIT_CNT_RESET, byte_clk: 1'b0, hold: sts_pkg::BYTE_RESET,
                        hold_valid: 1'b0, shift: sts_pkg::BYTE_RESET, pin_in_prev: 1'b0,
                        in_seen: 1'b0, in_period: sts_pkg::IN_PERIOD_RESET, period_err: 1'b0,
                        underrun: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign serial_tx_output = st_reg.shift[DATA_W-1];
    assign tx_byte_clock_pin_out = st_reg.byte_clk;
    assign tx_byte_clock_pin_oe = out_mode;
    assign byte_underrun = st_reg.underrun;
    assign byte_clock_period_err = st_reg.period_err;

endmodule : sts_tx_serializer

// ==== logic/sts_pkg.sv ====
// shared constants, types and helpers for the sonet transmit serializer
package sts_pkg;

    // ****************************************
    // byte and bit timing
    // ****************************************
    localparam int BYTE_BITS = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic [2:0] BIT_CNT_RESET = 3'h0;
    // byte clock is high for counts 0..3, low for 4..7
    localparam logic [2:0] BYTE_CLK_HIGH_LAST = 3'h3;
    localparam logic [7:0] IDLE_BYTE = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ****************************************
    // line rates in kbps and reference frequencies in kHz
    // ****************************************
    localparam int RATE_HIGH_KBPS = 622080;
    localparam int RATE_LOW_KBPS = 155520;
    localparam int REF_HIGH_KHZ = 77760;
    localparam int REF_LOW_KHZ = 19440;

    // ****************************************
    // clock multiplier lock detection
    // ****************************************
    localparam int REF_CNT_W = 7;
    localparam logic [6:0] REF_CNT_MAX = 7'h7f;
    localparam logic [6:0] REF_CNT_RESET = 7'h00;
    localparam int LOCK_CNT_W = 3;
    localparam logic [2:0] LOCK_COUNT = 3'h4;
    localparam logic [2:0] LOCK_CNT_RESET = 3'h0;

    // byte clock input period check counter
    localparam logic [5:0] IN_PERIOD_RESET = 6'h00;
    localparam logic [5:0] IN_PERIOD_MAX = 6'h3f;

    typedef enum logic [1:0] {
        STS_MULT_HUNT = 2'b01,
        STS_MULT_LOCK = 2'b10
    } sts_mult_state_t;

    // configuration pins grouped
    typedef struct packed {
        logic rate_high;
        logic ref_high;
        logic byte_clock_direction_sel;
    } sts_cfg_t;

    // serial clock cycles per reference period, as a function of rate and reference
    function automatic logic [6:0] sts_mult_ratio(input logic rate_high, input logic ref_high);
        int r;
        r = (rate_high ? RATE_HIGH_KBPS : RATE_LOW_KBPS) / (ref_high ? REF_HIGH_KHZ : REF_LOW_KHZ);
        return r[6:0];
    endfunction : sts_mult_ratio

endpackage : sts_pkg

// ==== logic/sts_clock_multiplier.sv ====
// reference combiner and lock monitor of the transmit clock multiplier
module sts_clock_multiplier (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // reference inputs
    input wire logic diff_reference_clock,
    input wire logic single_ended_reference_clock,
    // configuration
    input wire sts_pkg::sts_cfg_t cfg,
    // status
    output logic clock_multiplier_locked
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        sts_pkg::sts_mult_state_t fsm;
        logic ref_prev;
        logic seen_edge;
        logic [6:0] per_cnt;
        logic [2:0] good_cnt;
    } sts_mult_reg_t;

    sts_mult_reg_t st_reg;
    sts_mult_reg_t st_next;
    logic ref_comb;
    logic ref_rise;
    logic [6:0] ratio;
    logic period_ok;

    // unused input sits at ground, so xnor passes the active one (inverted)
    assign ref_comb = ~(diff_reference_clock ^ single_ended_reference_clock);
    assign ref_rise = ref_comb & ~st_reg.ref_prev;
    assign ratio = sts_pkg::sts_mult_ratio(cfg.rate_high, cfg.ref_high);
    assign period_ok = st_reg.seen_edge && (st_reg.per_cnt == ratio);

    always_comb begin
        st_next = st_reg;
        st_next.ref_prev = ref_comb;
        if (st_reg.per_cnt != sts_pkg::REF_CNT_MAX) begin
            st_next.per_cnt = st_reg.per_cnt + 7'h01;
        end
        if (ref_rise) begin
            st_next.seen_edge = 1'b1;
            st_next.per_cnt = 7'h01;
        end
        case (st_reg.fsm)
            sts_pkg::STS_MULT_HUNT: begin
                if (ref_rise) begin
                    if (period_ok) begin
                        st_next.good_cnt = st_reg.good_cnt + 3'h1;
                        if (st_reg.good_cnt + 3'h1 == sts_pkg::LOCK_COUNT) begin
                            st_next.fsm = sts_pkg::STS_MULT_LOCK;
                        end
                    end else begin
                        st_next.good_cnt = sts_pkg::LOCK_CNT_RESET;
                    end
                end
            end
            sts_pkg::STS_MULT_LOCK: begin
                // any wrong period or a stalled reference drops lock
                if ((ref_rise && !period_ok) || st_reg.per_cnt > ratio) begin
                    st_next.fsm = sts_pkg::STS_MULT_HUNT;
                    st_next.good_cnt = sts_pkg::LOCK_CNT_RESET;
                end
            end
            default: begin
                st_next.fsm = sts_pkg::STS_MULT_HUNT;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '{fsm: sts_pkg::STS_MULT_HUNT, ref_prev: 1'b0, seen_edge: 1'b0,
                        per_cnt: sts_pkg::REF_CNT_RESET, good_cnt: sts_pkg::LOCK_CNT_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign clock_multiplier_locked = (st_reg.fsm == sts_pkg::STS_MULT_LOCK);

endmodule : sts_clock_multiplier

// ==== verification/sts_framer_model.sv ====
// framer model: transmit bus, and the byte clock in input mode
module sts_framer_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // bench control
    input wire logic [5:0] period,
    input wire logic [7:0] data_byte,
    // pin side
    input wire logic pin_level,
    output logic pin_drive,
    output logic [7:0] tx_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cnt_reg;
    logic prev_reg;
    always_ff @(posedge clk) begin
        prev_reg <= pin_level;
        cnt_reg <= (sys_rst || cnt_reg + 6'h01 >= period) ? 6'h00 : cnt_reg + 6'h01;
        // period zero: clock stands still
        pin_drive <= !sys_rst && period != 6'h00 && cnt_reg < (period >> 1);
        // new byte on the falling edge, stable around the rising one
        if (sys_rst) begin
            tx_byte <= 8'h00;
        end else if (prev_reg && !pin_level) begin
            tx_byte <= data_byte;
        end
    end
endmodule : sts_framer_model

// ==== verification/sts_tx_chk.sv ====
// assertion checker for the transmit serializer
module sts_tx_chk #(
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // watched pins
    input wire logic byte_clock_direction_sel,
    input wire logic diff_reference_clock,
    input wire logic single_ended_reference_clock,
    input wire logic [DATA_W-1:0] tx_parallel_byte,
    input wire logic tx_byte_clock_pin_out,
    input wire logic tx_byte_clock_pin_oe,
    input wire logic serial_tx_output,
    input wire logic clock_multiplier_locked,
    input wire logic byte_underrun,
    input wire logic byte_clock_period_err
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // helpers
    // ****
    logic pd_reg;
    logic ref_d_reg;
    logic [7:0] ser_reg;
    logic [4:0] age_reg;
    logic [6:0] gap_reg;
    logic sel_d_reg;
    // age lags a mode change by one edge, so output mode must also hold one sample back
    wire logic mode_out = byte_clock_direction_sel & sel_d_reg;
    wire logic ref_c = ~(diff_reference_clock ^ single_ended_reference_clock);
    wire logic rise = tx_byte_clock_pin_out & ~pd_reg;
    always_ff @(posedge clk) begin
        pd_reg <= tx_byte_clock_pin_out;
        sel_d_reg <= byte_clock_direction_sel;
        ref_d_reg <= ref_c;
        ser_reg <= {ser_reg[6:0], serial_tx_output};
        gap_reg <= (ref_c & ~ref_d_reg) ? 7'h00 : gap_reg + 7'(gap_reg != 7'h7f);
        // age since reset or a direction change; masks settling phases
        if (sys_rst || $changed(byte_clock_direction_sel)) begin
            age_reg <= 5'h00;
        end else if (age_reg != 5'h1f) begin
            age_reg <= age_reg + 5'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ****
    // assertions
    // ****
    a_oe_follows_sel: assert property (tx_byte_clock_pin_oe == byte_clock_direction_sel)
        else $error("pin enable differs from direction select");
    a_byte_clock_shape: assert property ((rise && age_reg > 5'h04 && mode_out) |->
        tx_byte_clock_pin_out [*4] ##1 !tx_byte_clock_pin_out [*4] ##1 tx_byte_clock_pin_out)
        else $error("byte clock not four high and four low");
    a_msb_first: assert property (($past(rise, 15) && age_reg > 5'h14 && mode_out) |->
        {ser_reg[6:0], serial_tx_output} == $past(tx_parallel_byte, 15))
        else $error("captured byte not sent bit 7 first");
    a_no_underrun_out: assert property ((mode_out && age_reg > 5'h10) |-> !byte_underrun)
        else $error("underrun while byte clock is driven");
    a_no_period_out: assert property ((mode_out && age_reg > 5'h10) |-> !byte_clock_period_err)
        else $error("period error while byte clock is driven");
    a_underrun_idle: assert property (byte_underrun |-> ##1 !serial_tx_output [*6])
        else $error("underrun did not send idle bits");
    a_lock_drops: assert property ((gap_reg > 7'd36) |-> !clock_multiplier_locked)
        else $error("lock held without reference edges");
    a_lock_needs_ref: assert property ($rose(clock_multiplier_locked) |-> gap_reg < 7'd36)
        else $error("lock rose without a running reference");
    c_capture: cover property ($past(rise, 15) && age_reg > 5'h14 && byte_clock_direction_sel);
    c_underrun: cover property (byte_underrun);
    c_lock: cover property ($rose(clock_multiplier_locked));
endmodule : sts_tx_chk

bind sts_tx_serializer sts_tx_chk #(.DATA_W(DATA_W)) i_sts_tx_chk (.clk(clk), .sys_rst(sys_rst),
    .byte_clock_direction_sel(byte_clock_direction_sel), .diff_reference_clock(diff_reference_clock),
    .single_ended_reference_clock(single_ended_reference_clock), .tx_parallel_byte(tx_parallel_byte),
    .tx_byte_clock_pin_out(tx_byte_clock_pin_out), .tx_byte_clock_pin_oe(tx_byte_clock_pin_oe),
    .serial_tx_output(serial_tx_output), .clock_multiplier_locked(clock_multiplier_locked),
    .byte_underrun(byte_underrun), .byte_clock_period_err(byte_clock_period_err));

// ==== verification/tb_top.sv ====
// testbench for the transmit serializer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rate_high = 1'b1;
    logic ref_high = 1'b1;
    logic sel = 1'b1;
    logic use_se = 1'b0;
    logic ref_clk = 1'b0;
    logic [5:0] period = 6'h00;
    logic [7:0] data = 8'hc1;
    logic [7:0] bus;
    logic pin_out, pin_oe, pin_drive, ser, locked, undr, perr;
    int n_errors = 0;
    int tests_run = 0;
    int half = 0;
    int rcnt = 0;
    // unused reference held at ground
    wire logic diff_ref = ~use_se & ref_clk;
    wire logic se_ref = use_se & ref_clk;
    wire logic pin_lvl = pin_oe ? pin_out : pin_drive;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        rcnt <= (half == 0 || rcnt + 1 >= half) ? 0 : rcnt + 1;
        if (half != 0 && rcnt + 1 >= half) begin
            ref_clk <= ~ref_clk;
        end
    end
    sts_tx_serializer i_sts_tx_serializer (.clk(clk), .sys_rst(sys_rst), .rate_high(rate_high),
        .ref_high(ref_high), .byte_clock_direction_sel(sel), .diff_reference_clock(diff_ref),
        .single_ended_reference_clock(se_ref), .tx_parallel_byte(bus), .tx_byte_clock_pin_in(pin_lvl),
        .tx_byte_clock_pin_out(pin_out), .tx_byte_clock_pin_oe(pin_oe), .serial_tx_output(ser),
        .clock_multiplier_locked(locked), .byte_underrun(undr), .byte_clock_period_err(perr));
    sts_framer_model i_sts_framer_model (.clk(clk), .sys_rst(sys_rst), .period(period), .data_byte(data),
        .pin_level(pin_lvl), .pin_drive(pin_drive), .tx_byte(bus));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic watch(input int n, output logic [7:0] o, output logic [7:0] u, output logic [7:0] e);
        o = 8'h00;
        u = 8'h00;
        e = 8'h00;
        repeat (n) begin
            @(posedge clk);
            o = o + 8'(ser);
            u = u + 8'(undr);
            e = e + 8'(perr);
        end
    endtask : watch
    task automatic out_case(input logic [7:0] b);
        logic p;
        logic [7:0] got;
        data <= b;
        repeat (16) @(posedge clk);
        p = pin_out;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            if (pin_out && !p) break;
            p = pin_out;
        end
        repeat (7) @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk);
            got[i] = ser;
        end
        check("serial byte", b, got);
        check("pin enable", 8'h01, {7'h00, pin_oe});
    endtask : out_case
    task automatic in_case();
        logic [7:0] o, u, e;
        sel <= 1'b0;
        period <= 6'h08;
        // three ones per byte, so 64 bits hold 24
        data <= 8'hc1;
        repeat (40) @(posedge clk);
        // a steady byte repeats every 8 bits, so any window counts alike
        watch(64, o, u, e);
        check("ones", 8'h18, o);
        check("underruns", 8'h00, u + e);
        period <= 6'h00;
        repeat (16) @(posedge clk);
        watch(32, o, u, e);
        check("idle ones", 8'h00, o);
        check("idle underruns", 8'h04, u);
        period <= 6'h0a;
        repeat (24) @(posedge clk);
        watch(40, o, u, e);
        check("period errors", 8'h04, e);
        sel <= 1'b1;
        period <= 6'h00;
    endtask : in_case
    task automatic lock_case(input logic r, input logic f, input int ratio, input logic s);
        rate_high <= r;
        ref_high <= f;
        use_se <= s;
        half <= ratio / 2;
        repeat (300) @(posedge clk);
        check("locked", 8'h01, {7'h00, locked});
        half <= ratio;
        repeat (300) @(posedge clk);
        check("unlocked", 8'h00, {7'h00, locked});
    endtask : lock_case
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        out_case(8'hc1);
        out_case(8'h80);
        in_case();
        out_case(8'h01);
        lock_case(1'b1, 1'b1, 8, 1'b0);
        lock_case(1'b1, 1'b0, 32, 1'b1);
        lock_case(1'b0, 1'b1, 2, 1'b0);
        lock_case(1'b0, 1'b0, 8, 1'b1);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        out_case(8'h5a);
        stop_test();
    end
endmodule : tb_top
